// >>> emu_regs.vh
/*
  Timing and encoding constants for the emulation mode control block.
  Assumes a single 20 MHz processor oscillator clock with no dividers outside.
*/
`ifndef EMU_REGS_VH
`define EMU_REGS_VH

// ------------------------------------------------------------------
// state sequence
// ------------------------------------------------------------------
`define STATES_PER_CYCLE   6
`define PHASES_PER_STATE   2
`define STATE_W            3
`define STATE_S1           3'h0
`define STATE_S2           3'h1
`define STATE_S4           3'h3
`define STATE_LAST         3'h5

// ------------------------------------------------------------------
// forced instruction and exit timing
// ------------------------------------------------------------------
`define NOP_OPCODE         8'h00
`define EXIT_STATES        4
`define STATE_CNT_W        3

`endif

// >>> sync_2ff.v
/*
  Two flip-flop synchroniser for one level.
  Assumes clk is the oscillator clock and din may change at any time.
*/
`timescale 1ns/1ps
`default_nettype none

module sync_2ff (
  // clock and reset
  input  wire clk,
  input  wire rstn,
  // level
  input  wire din,
  output wire dout
);

  reg meta_reg;
  reg sync_reg;

  always @(posedge clk) begin
    if (!rstn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;

endmodule // sync_2ff

`default_nettype wire

// >>> state_sequencer.v
/*
  Machine state sequencer: two oscillator phases per state, six states per
  machine cycle. Advances only while run is high, so a stop lands on a
  whole-state boundary. Assumes run is a registered level on clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "emu_regs.vh"

module state_sequencer (
  // clock and reset
  input  wire                  clk,
  input  wire                  rstn,
  // control
  input  wire                  run,
  // sequence
  output reg                   phase_reg,
  output reg  [`STATE_W-1:0]   state_reg,
  output wire                  state_end
);

  // a state ends on the second phase while running
  assign state_end = run & phase_reg;

  always @(posedge clk) begin
    if (!rstn) begin
      phase_reg <= 1'b0;
      state_reg <= `STATE_S1;
    end else if (run) begin
      phase_reg <= ~phase_reg;
      if (phase_reg) begin
        if (state_reg == `STATE_LAST)
          state_reg <= `STATE_S1;
        else
          state_reg <= state_reg + 3'h1;
      end
    end
  end

endmodule // state_sequencer

`default_nettype wire

// >>> emulation_mode_control.v
/*
  Emulation mode control: freezes the internal state clock on an emulator
  request, reports emulation on an active indicator, forces a no-operation
  on exit, and steers the address-space select and external strobes.
  Assumes one 20 MHz oscillator clock; emulator pins are asynchronous;
  core-side inputs come from logic on clk. Pin pulls are pad cells outside.
  Only one emulator strobe is expected low at a time.
*/
// What this block does
// - normal mode: select low program, high data
// - emulation select low: internal state access allowed
// - emulation select high: external memory accessible
// - select high: data strobes weakly pulled only
// - standard type: port zero optionally floated
// - request defaults low by internal pull
// - request high: freeze states, oscillator runs
// - emulation exposes registers, counter, RAM, memory
// - request low: restart clock, resume prior mode
// - indicator rises end of next S1
// - exit loads no-operation opcode into instruction
// - first instruction after exit is no-operation
// - four states fetch ignored second byte
// - indicator falls four states after exit
// - output clock marks each first state
`timescale 1ns/1ps
`default_nettype none
`include "emu_regs.vh"

module emulation_mode_control #(
  parameter EXIT_STATES = `EXIT_STATES
) (
  // clock and reset
  input  wire       clk,
  input  wire       rstn,
  // emulator pins
  input  wire       emulation_request,
  input  wire       select_in,
  input  wire [1:0] upper_address_port,
  output reg        emulation_active,
  output reg        state_one_clock,
  // address-space select pin
  output reg        select_out,
  output reg        select_oe,
  // core side
  input  wire       standard_type,
  input  wire       port_zero_float_option,
  input  wire       core_data_access,
  input  wire       instr_boundary,
  input  wire [7:0] instruction_in,
  output reg  [7:0] instruction_register,
  output reg        state_run,
  output reg        internal_access_en,
  output reg        internal_write,
  output reg        internal_read,
  output reg        external_access_en,
  output reg        nop_forced,
  // external pins
  output reg        data_strobe_drive_en,
  output reg        port_zero_float
);

  // ------------------------------------------------------------------
  // state machine encodings
  // ------------------------------------------------------------------
  localparam [3:0] RUN_ST    = 4'b0001;
  localparam [3:0] ENTER_ST  = 4'b0010;
  localparam [3:0] FROZEN_ST = 4'b0100;
  localparam [3:0] EXIT_ST   = 4'b1000;

  // counter compares against the exit count less one, cut to its own width
  localparam integer            EXIT_LAST_I = EXIT_STATES - 1;
  localparam [`STATE_CNT_W-1:0] EXIT_LAST   = EXIT_LAST_I[`STATE_CNT_W-1:0];

  reg  [3:0]              mode_reg;
  reg  [3:0]              mode_next;
  reg  [`STATE_CNT_W-1:0] exit_cnt_reg;
  reg  [`STATE_CNT_W-1:0] exit_cnt_next;
  reg                     pending_reg;
  reg                     active_next;
  reg                     run_next;
  wire                    req_sync;
  wire                    sel_sync;
  wire [1:0]              strobe_sync;
  wire                    phase;
  wire [`STATE_W-1:0]     state;
  wire                    state_end;
  wire                    wr_strobe;
  wire                    rd_strobe;

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  // the pin pull-down itself sits in the pad; reset value keeps it low
  sync_2ff u_req_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  (emulation_request),
    .dout (req_sync)
  );

  sync_2ff u_sel_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  (select_in),
    .dout (sel_sync)
  );

  sync_2ff u_wr_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  (upper_address_port[0]),
    .dout (strobe_sync[0])
  );

  sync_2ff u_rd_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  (upper_address_port[1]),
    .dout (strobe_sync[1])
  );

  // ------------------------------------------------------------------
  // state sequencer
  // ------------------------------------------------------------------
  state_sequencer u_seq (
    .clk       (clk),
    .rstn      (rstn),
    .run       (state_run),
    .phase_reg (phase),
    .state_reg (state),
    .state_end (state_end)
  );

  // ------------------------------------------------------------------
  // request qualification
  // ------------------------------------------------------------------
  // request seen mid-instruction waits for the next instruction's S1
  always @(posedge clk) begin
    if (!rstn)
      pending_reg <= 1'b0;
    else if (!req_sync)
      pending_reg <= 1'b0;
    else if (instr_boundary)
      pending_reg <= 1'b1;
  end

  // ------------------------------------------------------------------
  // mode control
  // ------------------------------------------------------------------
  always @* begin
    mode_next     = mode_reg;
    exit_cnt_next = exit_cnt_reg;
    active_next   = emulation_active;
    run_next      = state_run;
    case (mode_reg)
      RUN_ST: begin
        run_next = 1'b1;
        if (pending_reg && req_sync && state == `STATE_S1 && state_end) begin
          mode_next   = ENTER_ST;
          active_next = 1'b1;
        end
      end
      ENTER_ST: begin
        // stop at the end of S2 so a whole state is kept
        if (state == `STATE_S2 && state_end) begin
          run_next  = 1'b0;
          mode_next = FROZEN_ST;
        end
      end
      FROZEN_ST: begin
        run_next = 1'b0;
        if (!req_sync) begin
          run_next      = 1'b1;
          exit_cnt_next = {`STATE_CNT_W{1'b0}};
          mode_next     = EXIT_ST;
        end
      end
      EXIT_ST: begin
        if (state_end) begin
          if (exit_cnt_reg == EXIT_LAST) begin
            active_next = 1'b0;
            mode_next   = RUN_ST;
          end else begin
            exit_cnt_next = exit_cnt_reg + 3'h1;
          end
        end
      end
      default: begin
        mode_next   = RUN_ST;
        run_next    = 1'b1;
        active_next = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // mode registers
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      mode_reg         <= RUN_ST;
      exit_cnt_reg     <= 3'h0;
      emulation_active <= 1'b0;
      state_run        <= 1'b1;
    end else begin
      mode_reg         <= mode_next;
      exit_cnt_reg     <= exit_cnt_next;
      emulation_active <= active_next;
      state_run        <= run_next;
    end
  end

  // ------------------------------------------------------------------
  // instruction register and forced no-operation
  // ------------------------------------------------------------------
  // pc may have moved while frozen, so the held opcode is stale
  always @(posedge clk) begin
    if (!rstn) begin
      instruction_register <= `NOP_OPCODE;
      nop_forced           <= 1'b0;
    end else if (mode_reg == FROZEN_ST && !req_sync) begin
      instruction_register <= `NOP_OPCODE;
      nop_forced           <= 1'b1;
    end else if (mode_reg == RUN_ST && state_run && instr_boundary) begin
      instruction_register <= instruction_in;
      nop_forced           <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // emulator strobe decode
  // ------------------------------------------------------------------
  // both strobes low is no legal cycle, so neither access is raised
  assign wr_strobe = ~sel_sync & ~strobe_sync[0] & strobe_sync[1];
  assign rd_strobe = ~sel_sync & ~strobe_sync[1] & strobe_sync[0];

  // ------------------------------------------------------------------
  // address-space select and access steering
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      select_out           <= 1'b0;
      select_oe            <= 1'b1;
      internal_access_en   <= 1'b0;
      internal_write       <= 1'b0;
      internal_read        <= 1'b0;
      external_access_en   <= 1'b0;
      data_strobe_drive_en <= 1'b1;
      port_zero_float      <= 1'b0;
    end else if (mode_reg == FROZEN_ST) begin
      // emulator owns the select pin while frozen
      select_out           <= 1'b0;
      select_oe            <= 1'b0;
      internal_access_en   <= ~sel_sync;
      internal_write       <= wr_strobe;
      internal_read        <= rd_strobe;
      external_access_en   <= sel_sync;
      data_strobe_drive_en <= ~sel_sync;
      port_zero_float      <= sel_sync & standard_type
                              & port_zero_float_option;
    end else begin
      select_out           <= core_data_access;
      select_oe            <= 1'b1;
      internal_access_en   <= 1'b0;
      internal_write       <= 1'b0;
      internal_read        <= 1'b0;
      external_access_en   <= 1'b0;
      data_strobe_drive_en <= 1'b1;
      port_zero_float      <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // state one clock
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rstn)
      state_one_clock <= 1'b0;
    else
      state_one_clock <= state_run & (state == `STATE_S1) & ~phase;
  end

endmodule // emulation_mode_control

`default_nettype wire

// >>> emc_chk.sv
/* emc_chk: port assertions for emulation_mode_control.
   Assumes one clock and a synchronous active-low rstn. */
`timescale 1ns/1ps
`default_nettype none
module emc_chk #(
  parameter EXIT_STATES = 4
) (
  // clock, reset and inputs
  input wire       clk,
  input wire       rstn,
  input wire       emulation_request,
  input wire       select_in,
  input wire       core_data_access,
  input wire       standard_type,
  input wire       port_zero_float_option,
  // outputs
  input wire       emulation_active,
  input wire       state_one_clock,
  input wire       select_out,
  input wire       select_oe,
  input wire       state_run,
  input wire [7:0] instruction_register,
  input wire       nop_forced,
  input wire       internal_access_en,
  input wire       external_access_en,
  input wire       data_strobe_drive_en,
  input wire       port_zero_float
);
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // five cycles cover the select synchroniser plus one register
  sequence s_frz(sel);
    (!state_run && select_in == sel) [*5];
  endsequence
  sequence s_hold;
    emulation_active [*7];
  endsequence
  property p_sel;
    $past(rstn) && $past(state_run) && !$past(emulation_active) && !emulation_active
      |-> select_out == $past(core_data_access);
  endproperty
  a_sel: assert property (p_sel) else $error("select level wrong");
  property p_frz;
    !state_run && !$past(state_run) |-> !select_oe && !state_one_clock;
  endproperty
  a_frz: assert property (p_frz) else $error("frozen outputs wrong");
  property p_sync;
    $rose(emulation_active) |-> $past(emulation_request, 3);
  endproperty
  a_sync: assert property (p_sync) else $error("entry too early");
  property p_entry;
    $rose(emulation_active) |-> state_run ##[1:4] !state_run;
  endproperty
  a_entry: assert property (p_entry) else $error("freeze timing");
  property p_nop;
    $rose(state_run) |-> instruction_register == 8'h00 && nop_forced;
  endproperty
  a_nop: assert property (p_nop) else $error("no forced nop");
  property p_exit;
    $rose(state_run) |-> s_hold ##[1:3] !emulation_active;
  endproperty
  a_exit: assert property (p_exit) else $error("indicator fall");
  property p_s1;
    state_one_clock |=> !state_one_clock [*8];
  endproperty
  a_s1: assert property (p_s1) else $error("state clock spacing");
  property p_int;
    s_frz(1'b0) |-> internal_access_en && !external_access_en;
  endproperty
  a_int: assert property (p_int) else $error("internal access");
  property p_ext;
    s_frz(1'b1) |-> external_access_en && !data_strobe_drive_en
      && port_zero_float == (standard_type && port_zero_float_option);
  endproperty
  a_ext: assert property (p_ext) else $error("external access");
endmodule // emc_chk
bind emulation_mode_control emc_chk #(.EXIT_STATES(EXIT_STATES)) u_emc_chk (
  .clk(clk), .rstn(rstn), .emulation_request(emulation_request), .select_in(select_in),
  .core_data_access(core_data_access), .standard_type(standard_type),
  .port_zero_float_option(port_zero_float_option), .emulation_active(emulation_active),
  .state_one_clock(state_one_clock), .select_out(select_out), .select_oe(select_oe),
  .state_run(state_run), .instruction_register(instruction_register),
  .nop_forced(nop_forced), .internal_access_en(internal_access_en),
  .external_access_en(external_access_en), .data_strobe_drive_en(data_strobe_drive_en),
  .port_zero_float(port_zero_float));
`default_nettype wire

// >>> emu_ice_model.sv
/* emu_ice_model: emulator side of request, select and strobes.
   Assumes the bench calls its tasks; each acts 2 ns after an edge. */
`timescale 1ns/1ps
`default_nettype none
module emu_ice_model (
  // clock
  input  wire        clk,
  // emulator pins
  output logic       emulation_request,
  output logic       select_drive,
  output logic       select_drive_en,
  output logic [1:0] upper_address_port
);
  // -----
  // tasks
  // -----
  initial begin
    emulation_request = 1'b0;
    select_drive = 1'b0;
    select_drive_en = 1'b0;
    upper_address_port = 2'h3;
  end
  task automatic set_req(input logic v);
    @(posedge clk);
    #2 emulation_request = v;
  endtask
  // drive select only while the device has let go of it
  task automatic set_sel(input logic en, input logic v);
    @(posedge clk);
    #2 select_drive_en = en;
    select_drive = v;
  endtask
  // bit 0 writes, bit 1 reads, both active low, used with select low
  task automatic strobe(input int b, input logic on);
    @(posedge clk);
    #2 upper_address_port = on ? ~(2'h1 << b) : 2'h3;
  endtask
endmodule // emu_ice_model
`default_nettype wire

// >>> emulation_mode_control_tb_top.sv
/* emulation_mode_control_tb_top: self-checking bench with emulator model.
   Assumes a 20 MHz clock; inputs change 2 ns after rising edges. */
`timescale 1ns/1ps
`default_nettype none
module emulation_mode_control_tb_top;
  localparam int EXIT_STATES = 4;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       standard_type = 1'b1;
  logic       port_zero_float_option = 1'b0;
  logic       core_data_access = 1'b0;
  logic       instr_boundary = 1'b0;
  logic [7:0] instruction_in = 8'h00;
  wire        emulation_request, select_in, select_out, select_oe, sel_drive, sel_en;
  wire        emulation_active, state_one_clock, state_run, nop_forced;
  wire        internal_access_en, internal_write, internal_read, external_access_en;
  wire        data_strobe_drive_en, port_zero_float;
  wire [1:0]  upper_address_port;
  wire [7:0]  instruction_register;
  int         bad_count = 0;
  int         n_tests = 0;
  int         n;
  int         pulses;
  int         ref_ir = 0;
  int         exp_q[$];
  // ------------
  // pins and dut
  // ------------
  // pad pull holds the select low when nobody drives it
  assign select_in = select_oe ? select_out : sel_en ? sel_drive : 1'b0;
  always #25 clk = ~clk;
  emulation_mode_control #(.EXIT_STATES(EXIT_STATES)) uut (
    .clk(clk), .rstn(rstn), .emulation_request(emulation_request), .select_in(select_in),
    .upper_address_port(upper_address_port), .emulation_active(emulation_active),
    .state_one_clock(state_one_clock), .select_out(select_out), .select_oe(select_oe),
    .standard_type(standard_type), .port_zero_float_option(port_zero_float_option),
    .core_data_access(core_data_access), .instr_boundary(instr_boundary),
    .instruction_in(instruction_in), .instruction_register(instruction_register),
    .state_run(state_run), .internal_access_en(internal_access_en),
    .internal_write(internal_write), .internal_read(internal_read),
    .external_access_en(external_access_en), .nop_forced(nop_forced),
    .data_strobe_drive_en(data_strobe_drive_en), .port_zero_float(port_zero_float));
  emu_ice_model ice (.clk(clk), .emulation_request(emulation_request),
    .select_drive(sel_drive), .select_drive_en(sel_en), .upper_address_port(upper_address_port));
  // -----
  // tasks
  // -----
  task automatic complete_run();
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic wt(input bit which, input logic v);
    n = 0;
    while ((which ? state_run : emulation_active) !== v) begin
      @(posedge clk);
      #2 n++;
      if (n > 300) begin
        check(1'b0, "wait ran out");
        complete_run();
      end
    end
  endtask
  task automatic do_reset();
    rstn = 1'b0;
    instr_boundary = 1'b0;
    repeat (3) @(posedge clk);
    #2 rstn = 1'b1;
    ref_ir = 0;
    check(emulation_active === 1'b0 && state_run === 1'b1 && select_oe === 1'b1, "reset");
    check(instruction_register === 8'h00 && data_strobe_drive_en === 1'b1, "reset");
  endtask
  // random core traffic against a reference of select level and held opcode
  task automatic run_normal(input int cycles);
    logic [31:0] r;
    int e;
    pulses = 0;
    repeat (cycles) begin
      r = $urandom;
      core_data_access = r[8];
      instr_boundary = r[9];
      instruction_in = r[7:0];
      if (r[9]) ref_ir = r[7:0];
      exp_q.push_back(r[8] * 256 + ref_ir);
      @(posedge clk);
      #2 pulses += (state_one_clock === 1'b1);
      e = exp_q.pop_front();
      check(select_out === e[8], "select level");
      check(instruction_register === e[7:0], "opcode");
    end
    check(pulses == cycles / 12, "state one clock");
  endtask
  initial begin
    n = $urandom(32'h37C9);
    do_reset();
    run_normal(24);
    for (int i = 0; i < 3; i++) begin
      // the other type is only ever chosen under reset
      if (i == 2) begin
        standard_type = 1'b0;
        do_reset();
      end
      port_zero_float_option = (i != 0);
      instr_boundary = 1'b0;
      ice.set_req(1'b1);
      repeat (16) @(posedge clk);
      #2 check(emulation_active === 1'b0, "entry without boundary");
      instr_boundary = 1'b1;
      wt(0, 1'b1);
      check(state_run === 1'b1, "stopped before entry");
      instr_boundary = 1'b0;
      wt(1, 1'b0);
      check(n <= 4, "freeze late");
      repeat (12) begin
        @(posedge clk);
        #2 check(state_one_clock === 1'b0 && state_run === 1'b0, "not frozen");
      end
      ice.set_sel(1'b1, 1'b0);
      for (int b = 0; b < 2; b++) begin
        ice.strobe(b, 1'b1);
        repeat (4 + 4 * i) @(posedge clk);
        #2 check(internal_write === (b == 0) && internal_read === (b == 1), "strobe");
        check(internal_access_en === 1'b1, "internal");
        ice.strobe(b, 1'b0);
      end
      ice.set_sel(1'b1, 1'b1);
      repeat (5) @(posedge clk);
      #2 check(external_access_en === 1'b1 && data_strobe_drive_en === 1'b0, "external");
      check(port_zero_float === (i == 1) && internal_access_en === 1'b0, "float");
      ice.set_sel(1'b0, 1'b0);
      ice.set_req(1'b0);
      wt(1, 1'b1);
      check(instruction_register === 8'h00 && nop_forced === 1'b1, "nop");
      ref_ir = 0;
      wt(0, 1'b0);
      check(n >= 2 * EXIT_STATES - 1 && n <= 2 * EXIT_STATES + 1, "exit");
      run_normal(24);
    end
    // reset while frozen must leave a clean running state
    ice.set_req(1'b1);
    instr_boundary = 1'b1;
    wt(1, 1'b0);
    do_reset();
    ice.set_req(1'b0);
    #200 run_normal(24);
    complete_run();
  end
endmodule // emulation_mode_control_tb_top
`default_nettype wire
